// file: bench/lpa_host.sv
// Bus master standing in for the decoder side of the slice
`timescale 1ns/1ns
`default_nettype none
module lpa_host (
	input wire logic clk,
	input wire logic [31:0] rdata,
	input wire logic wait_req,
	output logic [5:0] addr,
	output logic rd_en,
	output logic wr_en,
	output logic [31:0] wdata
);
	initial begin
		addr = 6'h00;
		rd_en = 1'b0;
		wr_en = 1'b0;
		wdata = 32'h0;
	end
	// Request held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		addr <= a;
		wr_en <= w;
		rd_en <= !w;
		wdata <= d;
		@(posedge clk);
		while (wait_req) @(posedge clk);
		q = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		// Released data lines show no stale value
		wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// file: bench/lpa_props.sv
// Bus handshake and interrupt assertions for the accumulate slice
`timescale 1ns/1ns
`default_nettype none
`include "lpa_defines.vh"
module lpa_props (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic IRQ
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("waitrequest stayed high after a request");
	wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	wait_cause_a: assert property (!AVS_WAITREQUEST |-> (AVS_READ || AVS_WRITE) && $past(AVS_WAITREQUEST))
		else $error("waitrequest low without a request");
	idle_wait_a: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest dropped while idle");
	handshake_pair_a: assert property (AVS_READ && AVS_WAITREQUEST |-> ##1 !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("read handshake not two cycles");
	rdata_hold_a: assert property ($changed(AVS_READDATA) |-> $past(AVS_READ && AVS_WAITREQUEST))
		else $error("read data changed without a read");
	unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > `LPA_REG_IRQMASK
		|-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	irq_fall_a: assert property ($fell(IRQ) |->
		$past((AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST, 2))
		else $error("interrupt dropped without an access");
endmodule
bind lpa_core lpa_props lpa_props_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the accumulate slice
`timescale 1ns/1ns
`default_nettype none
`include "lpa_defines.vh"
module testbench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] addr;
	logic rd_en;
	logic wr_en;
	logic wait_req;
	logic irq;
	logic [31:0] wdata;
	logic [31:0] rdata;
	int fail_count = 0;
	int tests_run = 0;
	always #5 core_clk = ~core_clk;
	lpa_core lpa_core_i (.CORE_CLK(core_clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .IRQ(irq));
	lpa_host lpa_host_i (.clk(core_clk), .rdata(rdata), .wait_req(wait_req), .addr(addr),
		.rd_en(rd_en), .wr_en(wr_en), .wdata(wdata));
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		lpa_host_i.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [5:0] a, output logic [31:0] q);
		lpa_host_i.xfer(1'b0, a, 32'h0, q);
	endtask
	task rchk(input string n, input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		rd(a, q);
		chk(n, q, exp);
	endtask
	task mset(input logic [31:0] a, input logic [31:0] d);
		wr(`LPA_REG_MEMADDR, a);
		wr(`LPA_REG_MEMDATA, d);
	endtask
	// Busy lasts at most three cycles, so polling starts once it has surely fallen
	task ex(input logic [15:0] op, input logic [15:0] k, input logic [31:0] go);
		logic [31:0] q;
		wr(`LPA_REG_INSTR, {16'h0, op});
		wr(`LPA_REG_LONGK, {16'h0, k});
		wr(`LPA_REG_GO, go);
		repeat (5) @(posedge core_clk);
		q = 32'h1;
		for (int i = 0; i < 20 && q[0] === 1'b1; i++) rd(`LPA_REG_GO, q);
		chk("idle", q & 32'h1, 32'h0);
	endtask
	// Edges from the accepted start until the done interrupt is seen high
	task ex_time(input logic [15:0] op, output int n);
		logic [31:0] q;
		wr(`LPA_REG_IRQMASK, 32'h1);
		rd(`LPA_REG_IRQSTS, q);
		wr(`LPA_REG_INSTR, {16'h0, op});
		wr(`LPA_REG_GO, 32'h1);
		n = 0;
		while (irq !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		rd(`LPA_REG_IRQSTS, q);
		wr(`LPA_REG_IRQMASK, 32'h0);
	endtask
	task t_inplace;
		mset(5, 32'h1111);
		wr(`LPA_REG_ACC, 32'h1234);
		wr(`LPA_REG_PC, 32'h10);
		ex(16'h5e05, 16'h0023, 1);
		wr(`LPA_REG_MEMADDR, 5);
		rchk("mem", `LPA_REG_MEMDATA, 32'h1);
		rchk("acc", `LPA_REG_ACC, 32'h1234);
		rchk("pc", `LPA_REG_PC, 32'h12);
		rchk("flags", `LPA_REG_GO, 32'h0);
		wr(`LPA_REG_BITMR, 32'hff00);
		ex(16'h5a05, 16'h0, 1);
		wr(`LPA_REG_MEMADDR, 5);
		rchk("mem", `LPA_REG_MEMDATA, 32'h0);
		rchk("pc", `LPA_REG_PC, 32'h13);
		rchk("flags", `LPA_REG_GO, 32'h8);
	endtask
	task t_and;
		int n0;
		int n1;
		wr(`LPA_REG_ACC, 32'h12345678);
		mset(5, 32'h00ff);
		ex(16'h6e05, 16'h0, 1);
		rchk("acc", `LPA_REG_ACC, 32'h78);
		ex_time(16'h6e05, n0);
		wr(`LPA_REG_CTRL, 32'h10);
		ex_time(16'h6e05, n1);
		chk("opnd_cycles", n1 - n0, 32'h1);
		wr(`LPA_REG_ACC, 32'h12345678);
		mset(5, 32'hff00);
		ex(16'h6e05, 16'h0, 1);
		rchk("acc", `LPA_REG_ACC, 32'h5600);
		// Sign mode set on purpose: the constant must still be zero-filled
		wr(`LPA_REG_CTRL, 32'h08);
		wr(`LPA_REG_ACC, 32'h12345678);
		ex(16'hbfb4, 16'h00ff, 1);
		rchk("acc", `LPA_REG_ACC, 32'h670);
		wr(`LPA_REG_ACC, 32'hffffffff);
		ex(16'hbe81, 16'h8000, 1);
		rchk("acc", `LPA_REG_ACC, 32'h80000000);
		wr(`LPA_REG_ACC, 32'h0f0fffff);
		wr(`LPA_REG_ACCUMULATOR_BUFFER, 32'h55555555);
		ex(16'hbe12, 16'h0, 1);
		rchk("acc", `LPA_REG_ACC, 32'h05055555);
		rchk("accumulator_buffer", `LPA_REG_ACCUMULATOR_BUFFER, 32'h55555555);
	endtask
	task t_product;
		logic [31:0] q;
		wr(`LPA_REG_CTRL, 32'h1);
		wr(`LPA_REG_PREG, 32'h40);
		wr(`LPA_REG_ACC, 32'h20);
		ex(16'hbe14, 16'h0, 1);
		rchk("acc", `LPA_REG_ACC, 32'ha0);
		wr(`LPA_REG_CTRL, 32'h3);
		wr(`LPA_REG_PREG, 32'h80000000);
		wr(`LPA_REG_ACC, 32'h0);
		ex(16'hbe14, 16'h0, 1);
		rchk("acc", `LPA_REG_ACC, 32'hfe000000);
		wr(`LPA_REG_CTRL, 32'h2);
		wr(`LPA_REG_PREG, 32'h1);
		wr(`LPA_REG_ACC, 32'h0);
		ex(16'h0, 16'h0, 2);
		rchk("acc", `LPA_REG_ACC, 32'h10);
		wr(`LPA_REG_CTRL, 32'h0);
		wr(`LPA_REG_PREG, 32'hffffffff);
		wr(`LPA_REG_ACC, 32'h1);
		ex(16'hbe14, 16'h0, 1);
		rchk("acc", `LPA_REG_ACC, 32'h0);
		rd(`LPA_REG_GO, q);
		chk("carry", q & 32'h4, 32'h4);
		wr(`LPA_REG_CTRL, 32'h4);
		wr(`LPA_REG_ACC, 32'h7fffffff);
		wr(`LPA_REG_PREG, 32'h1);
		ex(16'hbe14, 16'h0, 1);
		rchk("acc", `LPA_REG_ACC, 32'h7fffffff);
		rd(`LPA_REG_GO, q);
		chk("ovf", q & 32'h2, 32'h2);
	endtask
	task t_irq;
		logic [31:0] q;
		rd(`LPA_REG_IRQSTS, q);
		ex(16'hbe12, 16'h0, 1);
		chk("irq", {31'h0, irq}, 32'h0);
		rd(`LPA_REG_IRQSTS, q);
		chk("done", q & 32'h1, 32'h1);
		wr(`LPA_REG_IRQMASK, 32'h1);
		ex(16'hbe12, 16'h0, 1);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(`LPA_REG_IRQSTS, q);
		repeat (2) @(posedge core_clk);
		chk("irq", {31'h0, irq}, 32'h0);
		rchk("unmapped", 6'h3c, 32'h0);
		wr(`LPA_REG_INSTR, 32'h0);
		wr(`LPA_REG_GO, 32'h1);
		rd(`LPA_REG_IRQSTS, q);
		chk("illegal", q, 32'h8);
	endtask
	task wrap_up;
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rchk("ctrl", `LPA_REG_CTRL, 32'h0);
		rchk("mask", `LPA_REG_IRQMASK, 32'h0);
		t_inplace;
		t_and;
		t_product;
		t_irq;
		wrap_up;
	end
	// The whole sequence needs well under a tenth of this span
	initial begin
		#300000;
		fail_count++;
		wrap_up;
	end
endmodule
`default_nettype wire

// file: rtl/lpa_core.v
// Logic and product accumulate datapath slice with Avalon-MM register access
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "lpa_defines.vh"

module lpa_core (
	input wire CORE_CLK,
	input wire RST_N,
	input wire [5:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST,
	output reg IRQ
);

	localparam ST_IDLE = 2'h0;
	localparam ST_OPND = 2'h1;
	localparam ST_EXEC = 2'h2;

	localparam OP_NONE = 3'h0;
	localparam OP_AND_MEM = 3'h1;
	localparam OP_AND_K = 3'h2;
	localparam OP_AND_WITH_BUFFER_OP = 3'h3;
	localparam OP_ACCUM = 3'h4;
	localparam OP_APL = 3'h5;
	localparam OP_APL_K = 3'h6;

	reg [4:0] ctrl_ff;
	reg [15:0] instr_ff;
	reg [15:0] longk_ff;
	reg [31:0] acc_ff;
	reg [31:0] accumulator_buffer_ff;
	reg [31:0] preg_ff;
	reg [15:0] bitmr_ff;
	reg [15:0] pc_ff;
	reg [6:0] auxaddr_ff;
	reg [6:0] memaddr_ff;
	reg [15:0] mem_ff [0:127];
	reg ov_ff;
	reg c_ff;
	reg tc_ff;
	reg [3:0] irq_sts_ff;
	reg [3:0] irq_mask_ff;
	reg [1:0] state_ff;
	reg [2:0] op_ff;
	reg [1:0] cnt_ff;
	reg [6:0] opaddr_ff;
	reg [15:0] opnd_ff;

	wire bus_req = AVS_READ | AVS_WRITE;
	wire bus_done = bus_req & ~AVS_WAITREQUEST;
	wire wr_en = AVS_WRITE & ~AVS_WAITREQUEST;
	wire rd_en = AVS_READ & ~AVS_WAITREQUEST;
	wire busy = (state_ff != ST_IDLE);
	wire [1:0] pm = ctrl_ff[`LPA_CTRL_PM_LSB+1:`LPA_CTRL_PM_LSB];
	wire same_block = ctrl_ff[`LPA_CTRL_SAME];

	// Instruction decode
	reg [2:0] dec_op;
	reg [4:0] dec_shift;
	always @* begin
		dec_op = OP_NONE;
		dec_shift = 5'h00;
		if (instr_ff[15:8] == `LPA_OP_AND_HI) begin
			dec_op = OP_AND_MEM;
		end else if (instr_ff[15:8] == `LPA_OP_ANDK_HI &&
			instr_ff[7:4] == `LPA_OP_ANDK_MID) begin
			dec_op = OP_AND_K;
			dec_shift = {1'b0, instr_ff[3:0]};
		end else if (instr_ff == `LPA_OP_ANDK16) begin
			dec_op = OP_AND_K;
			dec_shift = 5'h10;
		end else if (instr_ff == `LPA_OP_AND_WITH_BUFFER_OP) begin
			dec_op = OP_AND_WITH_BUFFER_OP;
		end else if (instr_ff == `LPA_OP_ADD_PRODUCT_OP) begin
			dec_op = OP_ACCUM;
		end else if (instr_ff[15:8] == `LPA_OP_APL_HI) begin
			dec_op = OP_APL;
		end else if (instr_ff[15:8] == `LPA_OP_APLK_HI) begin
			dec_op = OP_APL_K;
		end
	end

	// Bit 7 picks the auxiliary address, otherwise the low seven bits are the address
	wire [6:0] dec_addr = instr_ff[7] ? auxaddr_ff : instr_ff[6:0];

	reg [4:0] shift_ff;

	// Long constant is zero filled on both sides, no sign extension
	wire [31:0] k_shifted = {16'h0000, longk_ff} << shift_ff;

	// Shifted product; sign bits always fill on the right shift
	reg [31:0] p_shifted;
	always @* begin
		case (pm)
			2'h0: p_shifted = preg_ff;
			2'h1: p_shifted = {preg_ff[30:0], 1'b0};
			2'h2: p_shifted = {preg_ff[27:0], 4'h0};
			2'h3: p_shifted = {{6{preg_ff[31]}}, preg_ff[31:6]};
			default: p_shifted = preg_ff;
		endcase
	end

	wire [32:0] p_sum = {1'b0, acc_ff} + {1'b0, p_shifted};
	wire p_ovf = (acc_ff[31] == p_shifted[31]) && (p_sum[31] != acc_ff[31]);
	reg [31:0] p_result;
	always @* begin
		if (p_ovf && ctrl_ff[`LPA_CTRL_OVM]) begin
			p_result = acc_ff[31] ? `LPA_SAT_NEG : `LPA_SAT_POS;
		end else begin
			p_result = p_sum[31:0];
		end
	end

	// In-place AND operand choice
	wire [15:0] apl_mask = (op_ff == OP_APL_K) ? longk_ff : bitmr_ff;
	wire [15:0] apl_result = opnd_ff & apl_mask;

	// Sequencer
	reg [1:0] nxt_state;
	reg [1:0] nxt_cnt;
	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (wr_en && AVS_ADDRESS == `LPA_REG_GO &&
					(AVS_WRITEDATA[`LPA_GO_ACCUM] ||
					(AVS_WRITEDATA[`LPA_GO_INSTR] && dec_op != OP_NONE))) begin
					nxt_state = ST_OPND;
					if (dec_op == OP_AND_MEM && same_block &&
						!AVS_WRITEDATA[`LPA_GO_ACCUM]) begin
						nxt_cnt = `LPA_OPND_SAME;
					end else begin
						nxt_cnt = `LPA_OPND_NORMAL;
					end
				end
			end
			ST_OPND: begin
				if (cnt_ff == 2'h0) begin
					nxt_state = ST_EXEC;
				end else begin
					nxt_cnt = cnt_ff - 2'h1;
				end
			end
			ST_EXEC: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	wire start = (state_ff == ST_IDLE) && (nxt_state == ST_OPND);
	wire exec = (state_ff == ST_EXEC);
	wire illegal = (state_ff == ST_IDLE) && wr_en && AVS_ADDRESS == `LPA_REG_GO &&
		AVS_WRITEDATA[`LPA_GO_INSTR] && !AVS_WRITEDATA[`LPA_GO_ACCUM] &&
		dec_op == OP_NONE;
	wire is_accum = (op_ff == OP_ACCUM);
	wire is_apl = (op_ff == OP_APL) || (op_ff == OP_APL_K);

	// Events for the interrupt status
	wire [3:0] events;
	assign events[`LPA_IRQ_DONE] = exec;
	assign events[`LPA_IRQ_OVF] = exec && is_accum && p_ovf;
	assign events[`LPA_IRQ_ZERO] = exec && is_apl && (apl_result == 16'h0000);
	assign events[`LPA_IRQ_ILLEGAL] = illegal;

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 2'h0;
			op_ff <= OP_NONE;
			shift_ff <= 5'h00;
			opaddr_ff <= 7'h00;
			opnd_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			if (start) begin
				op_ff <= AVS_WRITEDATA[`LPA_GO_ACCUM] ? OP_ACCUM : dec_op;
				shift_ff <= dec_shift;
				opaddr_ff <= dec_addr;
			end
			if (state_ff == ST_OPND) begin
				opnd_ff <= mem_ff[opaddr_ff];
			end
		end
	end

	// Architectural state; the executing operation wins over a bus write
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_ff <= `LPA_RST_CTRL;
			instr_ff <= 16'h0000;
			longk_ff <= 16'h0000;
			acc_ff <= 32'h00000000;
			accumulator_buffer_ff <= 32'h00000000;
			preg_ff <= 32'h00000000;
			bitmr_ff <= 16'h0000;
			pc_ff <= 16'h0000;
			auxaddr_ff <= 7'h00;
			memaddr_ff <= 7'h00;
			ov_ff <= 1'b0;
			c_ff <= 1'b0;
			tc_ff <= 1'b0;
			irq_mask_ff <= `LPA_RST_MASK;
		end else begin
			if (wr_en && !busy) begin
				case (AVS_ADDRESS)
					`LPA_REG_CTRL: ctrl_ff <= AVS_WRITEDATA[4:0];
					`LPA_REG_INSTR: instr_ff <= AVS_WRITEDATA[15:0];
					`LPA_REG_LONGK: longk_ff <= AVS_WRITEDATA[15:0];
					`LPA_REG_ACC: acc_ff <= AVS_WRITEDATA;
					`LPA_REG_ACCUMULATOR_BUFFER: accumulator_buffer_ff <= AVS_WRITEDATA;
					`LPA_REG_PREG: preg_ff <= AVS_WRITEDATA;
					`LPA_REG_BITMR: bitmr_ff <= AVS_WRITEDATA[15:0];
					`LPA_REG_PC: pc_ff <= AVS_WRITEDATA[15:0];
					`LPA_REG_AUXADDR: auxaddr_ff <= AVS_WRITEDATA[6:0];
					`LPA_REG_MEMADDR: memaddr_ff <= AVS_WRITEDATA[6:0];
					`LPA_REG_IRQMASK: irq_mask_ff <= AVS_WRITEDATA[3:0];
					`LPA_REG_GO: begin
						ov_ff <= ov_ff & ~AVS_WRITEDATA[`LPA_ST_OV];
					end
					default: ;
				endcase
			end
			if (exec) begin
				case (op_ff)
					OP_AND_MEM: begin
						acc_ff <= {16'h0000, acc_ff[15:0] & opnd_ff};
						pc_ff <= pc_ff + 16'h0001;
					end
					OP_AND_K: begin
						acc_ff <= acc_ff & k_shifted;
						pc_ff <= pc_ff + 16'h0002;
					end
					OP_AND_WITH_BUFFER_OP: begin
						acc_ff <= acc_ff & accumulator_buffer_ff;
						pc_ff <= pc_ff + 16'h0001;
					end
					OP_ACCUM: begin
						acc_ff <= p_result;
						c_ff <= p_sum[32];
						if (p_ovf) begin
							ov_ff <= 1'b1;
						end
						pc_ff <= pc_ff + 16'h0001;
					end
					OP_APL, OP_APL_K: begin
						tc_ff <= (apl_result == 16'h0000);
						if (op_ff == OP_APL_K) begin
							pc_ff <= pc_ff + 16'h0002;
						end else begin
							pc_ff <= pc_ff + 16'h0001;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Data memory; write-back lands at the operand's own address
	integer i;
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (i = 0; i < 128; i = i + 1) begin
				mem_ff[i] <= 16'h0000;
			end
		end else if (exec && is_apl) begin
			mem_ff[opaddr_ff] <= apl_result;
		end else if (wr_en && !busy && AVS_ADDRESS == `LPA_REG_MEMDATA) begin
			mem_ff[memaddr_ff] <= AVS_WRITEDATA[15:0];
		end
	end

	// Interrupt status: events set, a read of the register clears, set wins
	wire sts_clear = rd_en && AVS_ADDRESS == `LPA_REG_IRQSTS;
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_sts_ff <= 4'h0;
			IRQ <= 1'b0;
		end else begin
			// Only the bits that were reported are cleared, so an event caught between capture
			// and completion of the status read is not lost
			irq_sts_ff <= (sts_clear ? irq_sts_ff & ~AVS_READDATA[3:0] : irq_sts_ff) | events;
			IRQ <= |(irq_sts_ff & irq_mask_ff);
		end
	end

	// Read mux
	reg [31:0] rd_mux;
	always @* begin
		case (AVS_ADDRESS)
			`LPA_REG_CTRL: rd_mux = {27'h0, ctrl_ff};
			`LPA_REG_INSTR: rd_mux = {16'h0000, instr_ff};
			`LPA_REG_LONGK: rd_mux = {16'h0000, longk_ff};
			`LPA_REG_GO: rd_mux = {28'h0, tc_ff, c_ff, ov_ff, busy};
			`LPA_REG_ACC: rd_mux = acc_ff;
			`LPA_REG_ACCUMULATOR_BUFFER: rd_mux = accumulator_buffer_ff;
			`LPA_REG_PREG: rd_mux = preg_ff;
			`LPA_REG_BITMR: rd_mux = {16'h0000, bitmr_ff};
			`LPA_REG_PC: rd_mux = {16'h0000, pc_ff};
			`LPA_REG_AUXADDR: rd_mux = {25'h0, auxaddr_ff};
			`LPA_REG_MEMADDR: rd_mux = {25'h0, memaddr_ff};
			`LPA_REG_MEMDATA: rd_mux = {16'h0000, mem_ff[memaddr_ff]};
			`LPA_REG_IRQSTS: rd_mux = {28'h0, irq_sts_ff};
			`LPA_REG_IRQMASK: rd_mux = {28'h0, irq_mask_ff};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// One wait state on every access keeps read data registered
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h00000000;
		end else begin
			AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
			if (bus_req && AVS_WAITREQUEST && AVS_READ) begin
				AVS_READDATA <= rd_mux;
			end
		end
	end

endmodule

`default_nettype wire

// file: rtl/lpa_defines.vh
// Constants for the logic and product accumulate slice
`ifndef LPA_DEFINES_VH
`define LPA_DEFINES_VH

// Register byte offsets
`define LPA_REG_CTRL      6'h00
`define LPA_REG_INSTR     6'h04
`define LPA_REG_LONGK     6'h08
`define LPA_REG_GO        6'h0c
`define LPA_REG_ACC       6'h10
`define LPA_REG_ACCUMULATOR_BUFFER      6'h14
`define LPA_REG_PREG      6'h18
`define LPA_REG_BITMR     6'h1c
`define LPA_REG_PC        6'h20
`define LPA_REG_AUXADDR   6'h24
`define LPA_REG_MEMADDR   6'h28
`define LPA_REG_MEMDATA   6'h2c
`define LPA_REG_IRQSTS    6'h30
`define LPA_REG_IRQMASK   6'h34

// Control register fields
`define LPA_CTRL_PM_LSB   0
`define LPA_CTRL_OVM      2
`define LPA_CTRL_SXM      3
`define LPA_CTRL_SAME     4

// Go register write fields
`define LPA_GO_INSTR      0
`define LPA_GO_ACCUM      1

// Status fields of the go register on read
`define LPA_ST_BUSY       0
`define LPA_ST_OV         1
`define LPA_ST_C          2
`define LPA_ST_TC         3

// Interrupt status fields
`define LPA_IRQ_DONE      0
`define LPA_IRQ_OVF       1
`define LPA_IRQ_ZERO      2
`define LPA_IRQ_ILLEGAL   3

// Opcode patterns
`define LPA_OP_AND_HI     8'h6e
`define LPA_OP_ANDK_HI    8'hbf
`define LPA_OP_ANDK_MID   4'hb
`define LPA_OP_ANDK16     16'hbe81
`define LPA_OP_AND_WITH_BUFFER_OP       16'hbe12
`define LPA_OP_ADD_PRODUCT_OP       16'hbe14
`define LPA_OP_APL_HI     8'h5a
`define LPA_OP_APLK_HI    8'h5e

// Saturation limits
`define LPA_SAT_POS       32'h7fffffff
`define LPA_SAT_NEG       32'h80000000

// Operand stage extra cycles
`define LPA_OPND_NORMAL   2'h0
`define LPA_OPND_SAME     2'h1

// Reset values
`define LPA_RST_CTRL      5'h00
`define LPA_RST_MASK      4'h0

`endif
